// >>> rtl/positioning_command_checker.sv
/*
 Command checker for one pulse-output positioning channel: grants or rejects
 each command, records error codes, drives stop requests and output prohibit.
 Assumes commands and engine status arrive on core_clk; sensor pins are async.
*/
// What this block does
// - Direct start while operating is rejected with 34; operation continues.
// - Direct start while output prohibited is rejected with 35; channel stays stopped.
// - Direct start without established origin is rejected with 36 and stops.
// - Direct start speed must lie from 5 to speed limit, else 37 and stop.
// - Velocity run while operating is rejected with 38; operation continues.
// - Velocity run while output prohibited is rejected with 39; stays stopped.
// - Jog direction change during jog is refused with 3D; jog continues.
// - PWM while operating gives 3E and continues; while prohibited gives 3F, stop.
// - PWM period must be 1 to 20000, else 40 and stop.
// - PWM off-duty must be 0 to 100, else 41 and stop.
// - Speed override only while operating; idle override gives 42.
// - Override value outside 5 to speed limit gives 43; operation continues.
// - Override during deceleration gives 44; operation continues.
// - Origin return while operating gives 45; while prohibited gives 46 and stop.
// - Control selector must be 0 to 3, else 47.
// - Deceleration stop only while operating; idle request gives 48.
// - Origin return during jog gives 49; jog continues.
// - Position preset while operating gives 50; operation continues.
// - Direction change between continuous steps gives 51 and stops.
// - Emergency stop gives 52, held until cause gone and control clears it.
// - Stroke limits give 53 or 54, stop, prohibit; control clears and releases.
// - Limit tripping on the wrong travel side gives 55 and stops.
// - Error flag reads 1 while an error is present, else 0.
// - Operating flag reads 1 while busy, else 0.
`timescale 1ns/100ps
module positioning_command_checker (
    input wire logic core_clk,
    input wire logic sys_rst,
    input positioning_pkg::cmd_type cmd,
    input positioning_pkg::arg_type args,
    input positioning_pkg::engine_type eng,
    input wire logic estop_pin,
    input wire logic upper_limit_pin,
    input wire logic lower_limit_pin,
    output positioning_pkg::grant_type grant_q,
    output logic stop_req_q,
    output logic error_flag_q,
    output logic [7:0] error_code_q,
    output logic output_prohibit_q,
    output logic origin_set_q,
    output logic operating_q
);
    import positioning_pkg::*;

    function automatic logic speed_in_range(input logic [16:0] v, input logic [16:0] lim);
        return (v >= SPEED_MIN) && (v <= lim);
    endfunction

    // Codes after which the running operation carries on untouched
    function automatic logic keeps_running(input logic [7:0] code);
        return code inside {ERR_DST_BUSY, ERR_VEL_BUSY, ERR_JOG_BUSY, ERR_JOG_DIR,
                            ERR_PWM_BUSY, ERR_OVR_SPEED, ERR_OVR_DECEL, ERR_ORG_BUSY,
                            ERR_CTRL_SEL, ERR_ORG_JOG, ERR_PRESET_BUSY};
    endfunction

    // Pin order {lower, upper, estop}; meta stage feeds only the sync stage
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    logic [2:0] pin_prev_q;
    logic [7:0] error_code_d;
    logic output_prohibit_d;
    logic origin_set_d;

    wire logic [2:0] pin_rise = pin_sync_q & ~pin_prev_q;
    wire logic estop_level = pin_sync_q[0];
    wire logic upper_level = pin_sync_q[1];
    wire logic lower_level = pin_sync_q[2];
    wire logic busy = eng.busy;
    wire logic prohibited = output_prohibit_q;
    wire logic ctrl = cmd.positioning_control_cmd;
    wire logic [7:0] sel = args.control_sel;

    // Jogging off an active limit must stay possible while output is prohibited
    wire logic jog_escapes = (upper_level && args.jog_backward) ||
                             (lower_level && !args.jog_backward);

    wire logic [7:0] dst_code =
        !cmd.direct_position_start_cmd ? ERR_NONE :
        busy ? ERR_DST_BUSY :
        prohibited ? ERR_DST_PROHIBIT :
        !origin_set_q ? ERR_DST_NO_ORIGIN :
        !speed_in_range(args.op_speed, args.speed_limit) ? ERR_DST_SPEED :
        ERR_NONE;

    wire logic [7:0] vel_code =
        !cmd.velocity_run_cmd ? ERR_NONE :
        busy ? ERR_VEL_BUSY :
        prohibited ? ERR_VEL_PROHIBIT :
        !speed_in_range(args.op_speed, args.speed_limit) ? ERR_VEL_SPEED :
        ERR_NONE;

    wire logic jog_dir_differs = args.jog_backward != eng.moving_backward;
    wire logic [7:0] jog_code =
        !cmd.jog_run_cmd ? ERR_NONE :
        (eng.jog_active && jog_dir_differs) ? ERR_JOG_DIR :
        (eng.jog_active) ? ERR_NONE :
        busy ? ERR_JOG_BUSY :
        (prohibited && !jog_escapes) ? ERR_JOG_PROHIBIT :
        ERR_NONE;
    wire logic jog_retrigger = cmd.jog_run_cmd && eng.jog_active && !jog_dir_differs;

    wire logic [7:0] pwm_code =
        !cmd.pwm_output_cmd ? ERR_NONE :
        busy ? ERR_PWM_BUSY :
        prohibited ? ERR_PWM_PROHIBIT :
        (args.pwm_period < PWM_PERIOD_MIN || args.pwm_period > PWM_PERIOD_MAX) ?
            ERR_PWM_PERIOD :
        (args.pwm_off_duty > PWM_DUTY_MAX) ? ERR_PWM_DUTY :
        ERR_NONE;

    wire logic [7:0] ovr_code =
        !cmd.speed_override_cmd ? ERR_NONE :
        !busy ? ERR_OVR_IDLE :
        eng.decelerating ? ERR_OVR_DECEL :
        !speed_in_range(args.override_speed, args.speed_limit) ? ERR_OVR_SPEED :
        ERR_NONE;

    wire logic [7:0] org_code =
        !cmd.origin_return_cmd ? ERR_NONE :
        eng.jog_active ? ERR_ORG_JOG :
        busy ? ERR_ORG_BUSY :
        prohibited ? ERR_ORG_PROHIBIT :
        ERR_NONE;

    wire logic [7:0] ctrl_code =
        !ctrl ? ERR_NONE :
        (sel > CTRL_SEL_MAX) ? ERR_CTRL_SEL :
        (sel == CTRL_DECEL_STOP && !busy) ? ERR_DECEL_IDLE :
        (sel == CTRL_ESTOP) ? ERR_ESTOP :
        ERR_NONE;

    wire logic [7:0] prs_code =
        (cmd.current_position_preset_cmd && busy) ? ERR_PRESET_BUSY : ERR_NONE;

    // Sensor events outrank commands in the same cycle
    wire logic up_wrong = pin_rise[1] && busy && eng.moving_backward;
    wire logic low_wrong = pin_rise[2] && busy && !eng.moving_backward;
    wire logic [7:0] pin_code =
        pin_rise[0] ? ERR_ESTOP :
        (up_wrong || low_wrong) ? ERR_LIMIT_SWAP :
        pin_rise[1] ? ERR_UPPER_LIMIT :
        pin_rise[2] ? ERR_LOWER_LIMIT :
        (eng.step_dir_change && eng.continuous_mode) ? ERR_CONT_DIR :
        ERR_NONE;

    wire logic [7:0] new_code =
        pin_code != ERR_NONE ? pin_code :
        dst_code != ERR_NONE ? dst_code :
        vel_code != ERR_NONE ? vel_code :
        jog_code != ERR_NONE ? jog_code :
        pwm_code != ERR_NONE ? pwm_code :
        ovr_code != ERR_NONE ? ovr_code :
        org_code != ERR_NONE ? org_code :
        ctrl_code != ERR_NONE ? ctrl_code :
        prs_code;
    wire logic new_err = new_code != ERR_NONE;

    wire logic clear_req = ctrl && (sel == CTRL_CLEAR || sel == CTRL_CLEAR_RELEASE);
    // Clearing is blocked while the cause of a sticky error is still present
    wire logic clear_ok = clear_req && !estop_level &&
                          !(error_code_q == ERR_UPPER_LIMIT && upper_level) &&
                          !(error_code_q == ERR_LOWER_LIMIT && lower_level);
    wire logic release_ok = ctrl && sel == CTRL_CLEAR_RELEASE &&
                            !upper_level && !lower_level;
    wire logic limit_err = new_code == ERR_UPPER_LIMIT || new_code == ERR_LOWER_LIMIT;

    wire grant_type grant_d = '{
        start_position: cmd.direct_position_start_cmd && dst_code == ERR_NONE,
        start_velocity: cmd.velocity_run_cmd && vel_code == ERR_NONE,
        start_jog: cmd.jog_run_cmd && jog_code == ERR_NONE && !jog_retrigger,
        start_pwm: cmd.pwm_output_cmd && pwm_code == ERR_NONE,
        apply_override: cmd.speed_override_cmd && ovr_code == ERR_NONE,
        start_origin: cmd.origin_return_cmd && org_code == ERR_NONE,
        apply_preset: cmd.current_position_preset_cmd && prs_code == ERR_NONE,
        decel_stop: ctrl && sel == CTRL_DECEL_STOP && busy
    };
    wire logic stop_d = new_err && !keeps_running(new_code);

    // A new error wins over a clear arriving in the same cycle
    assign error_code_d = new_err ? new_code : clear_ok ? ERR_NONE : error_code_q;
    assign output_prohibit_d = limit_err ? 1'b1 : release_ok ? 1'b0 : output_prohibit_q;
    assign origin_set_d = origin_set_q || eng.origin_done || grant_d.apply_preset;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_meta_q <= 3'h0;
            pin_sync_q <= 3'h0;
            pin_prev_q <= 3'h0;
        end else begin
            pin_meta_q <= {lower_limit_pin, upper_limit_pin, estop_pin};
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            grant_q <= '0;
            stop_req_q <= 1'b0;
            error_code_q <= ERR_NONE;
            error_flag_q <= 1'b0;
            output_prohibit_q <= 1'b0;
            origin_set_q <= 1'b0;
            operating_q <= 1'b0;
        end else begin
            grant_q <= grant_d;
            stop_req_q <= stop_d;
            error_code_q <= error_code_d;
            error_flag_q <= error_code_d != ERR_NONE;
            output_prohibit_q <= output_prohibit_d;
            origin_set_q <= origin_set_d;
            operating_q <= eng.busy;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_dst_busy_keeps: assert property (
        cmd.direct_position_start_cmd && busy && pin_code == ERR_NONE |=>
        !grant_q.start_position && error_code_q == ERR_DST_BUSY && !stop_req_q)
        else $error("direct start during operation not rejected with 34");
    a_dst_prohibit: assert property (
        cmd.direct_position_start_cmd && !busy && prohibited && pin_code == ERR_NONE |=>
        !grant_q.start_position && error_code_q == ERR_DST_PROHIBIT && stop_req_q)
        else $error("direct start while prohibited not stopped with 35");
    a_dst_origin: assert property (
        cmd.direct_position_start_cmd && !busy && !prohibited && !origin_set_q &&
        pin_code == ERR_NONE |=> error_code_q == ERR_DST_NO_ORIGIN && stop_req_q)
        else $error("direct start without origin not stopped with 36");
    a_dst_speed: assert property (
        cmd.direct_position_start_cmd && !busy && !prohibited && origin_set_q &&
        !speed_in_range(args.op_speed, args.speed_limit) && pin_code == ERR_NONE |=>
        error_code_q == ERR_DST_SPEED && stop_req_q)
        else $error("direct start speed out of range not stopped with 37");
    a_dst_start_ok: assert property (grant_q.start_position |->
        $past(origin_set_q) && !$past(output_prohibit_q) && !$past(eng.busy) &&
        $past(args.op_speed) >= SPEED_MIN && $past(args.op_speed) <= $past(args.speed_limit))
        else $error("direct start granted without its preconditions");
    a_vel_busy: assert property (
        cmd.velocity_run_cmd && busy && pin_code == ERR_NONE && dst_code == ERR_NONE |=>
        error_code_q == ERR_VEL_BUSY && !stop_req_q && !grant_q.start_velocity)
        else $error("velocity run during operation not rejected with 38");
    a_vel_prohibit: assert property (
        cmd.velocity_run_cmd && !busy && prohibited && pin_code == ERR_NONE &&
        dst_code == ERR_NONE |=> error_code_q == ERR_VEL_PROHIBIT && stop_req_q)
        else $error("velocity run while prohibited not stopped with 39");
    a_jog_dir: assert property (
        cmd.jog_run_cmd && eng.jog_active && jog_dir_differs && pin_code == ERR_NONE &&
        dst_code == ERR_NONE && vel_code == ERR_NONE |=>
        error_code_q == ERR_JOG_DIR && !stop_req_q && !grant_q.start_jog)
        else $error("jog direction change not refused with 3d");
    a_pwm_period_ok: assert property (grant_q.start_pwm |->
        $past(args.pwm_period) >= PWM_PERIOD_MIN && $past(args.pwm_period) <= PWM_PERIOD_MAX
        && $past(args.pwm_off_duty) <= PWM_DUTY_MAX)
        else $error("pwm granted with period or duty out of range");
    a_pwm_busy_code: assert property (
        cmd.pwm_output_cmd && busy && new_code == ERR_PWM_BUSY |=>
        error_code_q == ERR_PWM_BUSY && !stop_req_q && !grant_q.start_pwm)
        else $error("pwm during operation not rejected with 3e");
    a_override_state: assert property (grant_q.apply_override |->
        $past(eng.busy) && !$past(eng.decelerating))
        else $error("override granted while idle or decelerating");
    a_override_range: assert property (new_code == ERR_OVR_SPEED |=>
        error_code_q == ERR_OVR_SPEED && !stop_req_q)
        else $error("override out of range not kept running with 43");
    a_origin_block: assert property (grant_q.start_origin |->
        !$past(eng.jog_active) && !$past(eng.busy) && !$past(output_prohibit_q))
        else $error("origin return granted while jogging, busy or prohibited");
    a_decel_busy: assert property (grant_q.decel_stop |-> $past(eng.busy))
        else $error("deceleration stop granted while idle");
    a_ctrl_sel_range: assert property (
        ctrl && sel > CTRL_SEL_MAX && pin_code == ERR_NONE &&
        dst_code == ERR_NONE && vel_code == ERR_NONE && jog_code == ERR_NONE &&
        pwm_code == ERR_NONE && ovr_code == ERR_NONE && org_code == ERR_NONE
        |=> error_code_q == ERR_CTRL_SEL)
        else $error("bad control selector not reported as 47");
    a_preset_busy: assert property (cmd.current_position_preset_cmd && busy |=>
        !grant_q.apply_preset)
        else $error("position preset granted during operation");
    a_estop_pin: assert property (pin_rise[0] |=>
        error_code_q == ERR_ESTOP && stop_req_q)
        else $error("emergency stop input not stopped with 52");
    a_estop_sticky: assert property (error_code_q == ERR_ESTOP && estop_level |=>
        error_flag_q && error_code_q != ERR_NONE)
        else $error("emergency stop error cleared while cause present");
    a_limit_prohibit: assert property (
        pin_rise[1] && !pin_rise[0] && !up_wrong && !low_wrong |=>
        output_prohibit_q && error_code_q == ERR_UPPER_LIMIT && stop_req_q)
        else $error("upper limit did not stop and prohibit");
    a_prohibit_hold: assert property (
        output_prohibit_q && (upper_level || lower_level) |=> output_prohibit_q)
        else $error("output prohibit released while a limit is active");
    a_swap_stop: assert property ((up_wrong || low_wrong) && !pin_rise[0] |=>
        error_code_q == ERR_LIMIT_SWAP && stop_req_q)
        else $error("wrong side limit not reported as 55");
    a_cont_dir: assert property (
        eng.step_dir_change && eng.continuous_mode && pin_rise == 3'h0 |=>
        error_code_q == ERR_CONT_DIR && stop_req_q)
        else $error("continuous direction change not stopped with 51");
    a_flag_matches: assert property (error_flag_q == (error_code_q != ERR_NONE))
        else $error("error flag disagrees with error code");
    a_busy_flag: assert property (operating_q == $past(eng.busy))
        else $error("operating flag does not follow busy");

    c_start_granted: cover property (grant_q.start_position);
    c_estop_cleared: cover property (error_code_q == ERR_ESTOP ##[1:50] error_code_q == ERR_NONE);
    c_prohibit_released: cover property ($fell(output_prohibit_q));
    c_jog_dir_refused: cover property (error_code_q == ERR_JOG_DIR);
    c_limit_swap: cover property (error_code_q == ERR_LIMIT_SWAP);
endmodule

// >>> rtl/positioning_pkg.sv
/*
 Constants, error codes and carrier types for the positioning command checker.
 Assumes one channel per instance and a motion engine on the same clock.
*/
package positioning_pkg;

    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_DST_BUSY = 8'h34;
    localparam logic [7:0] ERR_DST_PROHIBIT = 8'h35;
    localparam logic [7:0] ERR_DST_NO_ORIGIN = 8'h36;
    localparam logic [7:0] ERR_DST_SPEED = 8'h37;
    localparam logic [7:0] ERR_VEL_BUSY = 8'h38;
    localparam logic [7:0] ERR_VEL_PROHIBIT = 8'h39;
    localparam logic [7:0] ERR_VEL_SPEED = 8'h3a;
    localparam logic [7:0] ERR_JOG_BUSY = 8'h3b;
    localparam logic [7:0] ERR_JOG_PROHIBIT = 8'h3c;
    localparam logic [7:0] ERR_JOG_DIR = 8'h3d;
    localparam logic [7:0] ERR_PWM_BUSY = 8'h3e;
    localparam logic [7:0] ERR_PWM_PROHIBIT = 8'h3f;
    localparam logic [7:0] ERR_PWM_PERIOD = 8'h40;
    localparam logic [7:0] ERR_PWM_DUTY = 8'h41;
    localparam logic [7:0] ERR_OVR_IDLE = 8'h42;
    localparam logic [7:0] ERR_OVR_SPEED = 8'h43;
    localparam logic [7:0] ERR_OVR_DECEL = 8'h44;
    localparam logic [7:0] ERR_ORG_BUSY = 8'h45;
    localparam logic [7:0] ERR_ORG_PROHIBIT = 8'h46;
    localparam logic [7:0] ERR_CTRL_SEL = 8'h47;
    localparam logic [7:0] ERR_DECEL_IDLE = 8'h48;
    localparam logic [7:0] ERR_ORG_JOG = 8'h49;
    localparam logic [7:0] ERR_PRESET_BUSY = 8'h50;
    localparam logic [7:0] ERR_CONT_DIR = 8'h51;
    localparam logic [7:0] ERR_ESTOP = 8'h52;
    localparam logic [7:0] ERR_UPPER_LIMIT = 8'h53;
    localparam logic [7:0] ERR_LOWER_LIMIT = 8'h54;
    localparam logic [7:0] ERR_LIMIT_SWAP = 8'h55;

    localparam logic [16:0] SPEED_MIN = 17'h00005;
    localparam logic [15:0] PWM_PERIOD_MIN = 16'h0001;
    localparam logic [15:0] PWM_PERIOD_MAX = 16'h4e20;
    localparam logic [7:0] PWM_DUTY_MAX = 8'h64;

    // Control command selector values
    localparam logic [7:0] CTRL_DECEL_STOP = 8'h00;
    localparam logic [7:0] CTRL_ESTOP = 8'h01;
    localparam logic [7:0] CTRL_CLEAR = 8'h02;
    localparam logic [7:0] CTRL_CLEAR_RELEASE = 8'h03;
    localparam logic [7:0] CTRL_SEL_MAX = 8'h03;

    typedef struct packed {
        logic direct_position_start_cmd;
        logic velocity_run_cmd;
        logic jog_run_cmd;
        logic pwm_output_cmd;
        logic speed_override_cmd;
        logic origin_return_cmd;
        logic positioning_control_cmd;
        logic current_position_preset_cmd;
    } cmd_type;

    typedef struct packed {
        logic [16:0] op_speed;
        logic [16:0] speed_limit;
        logic [16:0] override_speed;
        logic [15:0] pwm_period;
        logic [7:0] pwm_off_duty;
        logic [7:0] control_sel;
        logic jog_backward;
    } arg_type;

    typedef struct packed {
        logic busy;
        logic jog_active;
        logic decelerating;
        logic moving_backward;
        logic continuous_mode;
        logic step_dir_change;
        logic origin_done;
    } engine_type;

    typedef struct packed {
        logic start_position;
        logic start_velocity;
        logic start_jog;
        logic start_pwm;
        logic apply_override;
        logic start_origin;
        logic apply_preset;
        logic decel_stop;
    } grant_type;

endpackage

// >>> dv/engine_model.sv
/*
 Behavioural motion engine that answers the checker's grants with status.
 Assumes grants and stop requests are one-cycle pulses on core_clk.
*/
`timescale 1ns/100ps
module engine_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input positioning_pkg::grant_type grant,
    input wire logic stop_req,
    input wire logic back_i,
    input wire logic cont_i,
    output positioning_pkg::engine_type eng
);
    import positioning_pkg::*;
    logic [5:0] cnt_q;
    logic jog_q;
    logic org_q;
    logic back_q;
    wire start = grant.start_position | grant.start_velocity | grant.start_jog
        | grant.start_pwm | grant.start_origin;
    assign eng.busy = cnt_q != 6'h00;
    assign eng.jog_active = jog_q & eng.busy;
    assign eng.decelerating = eng.busy & (cnt_q <= 6'h05);
    assign eng.moving_backward = back_q;
    assign eng.continuous_mode = cont_i;
    // A direction flip only happens when the bench asks for continuous mode
    assign eng.step_dir_change = cont_i & (cnt_q == 6'h0f);
    assign eng.origin_done = org_q & (cnt_q == 6'h01);
    always_ff @(posedge core_clk) begin
        if (sys_rst || stop_req) begin // Halts on every stop-class error
            cnt_q <= 6'h00;
        end else if (start) begin
            cnt_q <= 6'h28;
        end else if (grant.decel_stop && cnt_q > 6'h05) begin
            cnt_q <= 6'h05;
        end else if (eng.busy) begin
            cnt_q <= cnt_q - 6'h01;
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            jog_q <= 1'b0;
            org_q <= 1'b0;
            back_q <= 1'b0;
        end else if (start) begin
            jog_q <= grant.start_jog;
            org_q <= grant.start_origin;
            back_q <= back_i;
        end
    end
endmodule

// >>> dv/positioning_command_checker_test.sv
/*
 Self-checking bench for the command checker with a behavioural engine.
 Assumes stimulus at the falling edge and registered answers one cycle later.
*/
`timescale 1ns/100ps
module positioning_command_checker_test;
    import positioning_pkg::*;
    localparam int DST = 7, VEL = 6, JOG = 5, PWM = 4, OVR = 3, ORG = 2, CTL = 1, PRS = 0;
    logic clk = 1'b0, rst = 1'b1, e = 1'b0, u = 1'b0, l = 1'b0, back = 1'b0, cont = 1'b0;
    cmd_type c = '0;
    arg_type a = '0;
    grant_type g;
    engine_type eng;
    logic stp, flg, proh, orgs, opq;
    logic [7:0] code;
    int miscompares = 0, total_checks = 0, cyc = 0, seed = 7;
    int bk [6] = '{DST, VEL, PWM, ORG, JOG, PRS};
    logic [7:0] bc [6] = '{8'h34, 8'h38, 8'h3e, 8'h45, 8'h3b, 8'h50};
    logic [7:0] pc [5] = '{8'h35, 8'h39, 8'h3f, 8'h46, 8'h3c};
    logic [16:0] corner [4] = '{17'h00004, 17'h00005, 17'h003e8, 17'h003e9};
    logic [15:0] pp [4] = '{16'h0000, 16'h4e21, 16'h4e20, 16'h0001};
    logic [7:0] pd [4] = '{8'h00, 8'h00, 8'h65, 8'h64};
    logic [7:0] pe [4] = '{8'h40, 8'h40, 8'h41, 8'h00};
    logic [16:0] s;
    positioning_command_checker dut (.core_clk(clk), .sys_rst(rst), .cmd(c), .args(a),
        .eng(eng), .estop_pin(e), .upper_limit_pin(u), .lower_limit_pin(l), .grant_q(g),
        .stop_req_q(stp), .error_flag_q(flg), .error_code_q(code),
        .output_prohibit_q(proh), .origin_set_q(orgs), .operating_q(opq));
    engine_model partner (.core_clk(clk), .sys_rst(rst), .grant(g), .stop_req(stp),
        .back_i(back), .cont_i(cont), .eng(eng));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        // Whole run needs about 1000 cycles
        if (cyc > 8000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic fail(input string m);
        miscompares++;
        $display("CHECK FAILED %0t %s", $time, m);
    endtask
    task automatic check_code(input logic [7:0] ec, input logic es);
        total_checks++;
        if (code !== ec || stp !== es || flg !== (ec != 8'h00)) fail("error code/stop/flag");
    endtask
    task automatic check_grant(input logic [7:0] eg);
        total_checks++;
        if (g !== grant_type'(eg)) fail("grant");
    endtask
    task automatic check_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) fail("status bit");
    endtask
    task automatic go(input int k);
        @(negedge clk);
        c = cmd_type'(8'h01 << k);
        @(negedge clk);
        c = '0;
    endtask
    task automatic ctrl(input logic [7:0] sel);
        a.control_sel = sel;
        go(CTL);
    endtask
    task automatic wait_idle();
        // A fresh grant reaches the engine one edge later
        @(negedge clk);
        for (int i = 0; i < 80 && eng.busy !== 1'b0; i++) @(negedge clk);
        repeat (2) @(negedge clk);
    endtask
    task automatic wait_stp();
        // Continuous-mode flip comes about 25 cycles into a run
        for (int i = 0; i < 40 && stp !== 1'b1; i++) @(negedge clk);
    endtask
    function automatic logic [7:0] exp_dst(input logic [16:0] v);
        return (v < SPEED_MIN || v > a.speed_limit) ? ERR_DST_SPEED : ERR_NONE;
    endfunction
    initial begin
        a.speed_limit = 17'h003e8;
        a.op_speed = 17'h00064;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        check_code(8'h00, 1'b0);
        go(DST);
        check_code(8'h36, 1'b1);
        ctrl(8'h02);
        check_code(8'h00, 1'b0);
        go(OVR);
        check_code(8'h42, 1'b1);
        ctrl(8'h00);
        check_code(8'h48, 1'b1);
        ctrl(8'h04 + 8'({$random(seed)} % 252));
        check_code(8'h47, 1'b0);
        ctrl(8'h02);
        go(ORG);
        check_grant(8'h04);
        wait_idle();
        check_bit(orgs, 1'b1);
        for (int i = 0; i < 14; i++) begin
            s = (i < 4) ? corner[i] : 17'({$random(seed)} % 1010);
            a.op_speed = s;
            go(DST);
            if (exp_dst(s) != ERR_NONE) check_code(exp_dst(s), 1'b1);
            else check_grant(8'h80);
            wait_idle();
            ctrl(8'h02);
        end
        a.op_speed = corner[0];
        go(VEL);
        check_code(8'h3a, 1'b1);
        ctrl(8'h02);
        a.op_speed = 17'h00064;
        go(DST);
        repeat (2) @(negedge clk);
        check_bit(opq, 1'b1);
        for (int i = 0; i < 6; i++) begin
            go(bk[i]);
            check_code(bc[i], 1'b0);
        end
        a.override_speed = 17'h00004;
        go(OVR);
        check_code(8'h43, 1'b0);
        a.override_speed = 17'h003e9;
        go(OVR);
        check_code(8'h43, 1'b0);
        a.override_speed = 17'h00005 + 17'({$random(seed)} % 996);
        go(OVR);
        check_grant(8'h08);
        for (int i = 0; i < 80 && eng.decelerating !== 1'b1; i++) @(negedge clk);
        go(OVR);
        check_code(8'h44, 1'b0);
        wait_idle();
        check_bit(opq, 1'b0);
        ctrl(8'h02);
        go(DST);
        @(negedge clk);
        ctrl(8'h00);
        check_grant(8'h01);
        wait_idle();
        for (int i = 0; i < 4; i++) begin
            a.pwm_period = pp[i];
            a.pwm_off_duty = pd[i];
            go(PWM);
            if (pe[i] != 8'h00) check_code(pe[i], 1'b1);
            else check_grant(8'h10);
            wait_idle();
            ctrl(8'h02);
        end
        go(JOG);
        check_grant(8'h20);
        @(negedge clk);
        a.jog_backward = 1'b1;
        go(JOG);
        check_code(8'h3d, 1'b0);
        go(ORG);
        check_code(8'h49, 1'b0);
        wait_idle();
        ctrl(8'h02);
        go(JOG);
        check_grant(8'h20);
        wait_idle();
        cont = 1'b1;
        go(VEL);
        check_grant(8'h40);
        wait_stp();
        check_code(8'h51, 1'b1);
        cont = 1'b0;
        ctrl(8'h02);
        back = 1'b1;
        go(VEL);
        @(negedge clk);
        u = 1'b1;
        wait_stp();
        check_code(8'h55, 1'b1);
        check_bit(proh, 1'b0);
        u = 1'b0;
        back = 1'b0;
        repeat (4) @(negedge clk);
        ctrl(8'h02);
        l = 1'b1;
        wait_stp();
        check_code(8'h54, 1'b1);
        check_bit(proh, 1'b1);
        a.jog_backward = 1'b0;
        go(JOG);
        check_grant(8'h20);
        ctrl(8'h03);
        check_code(8'h54, 1'b0);
        l = 1'b0;
        wait_idle();
        ctrl(8'h03);
        check_code(8'h00, 1'b0);
        check_bit(proh, 1'b0);
        u = 1'b1;
        wait_stp();
        check_code(8'h53, 1'b1);
        u = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 5; i++) begin
            go(bk[i]);
            check_code(pc[i], 1'b1);
        end
        ctrl(8'h03);
        check_bit(proh, 1'b0);
        e = 1'b1;
        wait_stp();
        check_code(8'h52, 1'b1);
        ctrl(8'h02);
        check_code(8'h52, 1'b0);
        e = 1'b0;
        repeat (3) @(negedge clk);
        ctrl(8'h02);
        check_code(8'h00, 1'b0);
        ctrl(8'h01);
        check_code(8'h52, 1'b1);
        ctrl(8'h02);
        go(PRS);
        check_grant(8'h02);
        conclude();
    end
endmodule
